// >>> core/string_store_ordering.sv
`timescale 1ns/1ns
module string_store_ordering
  import string_order_pkg::*;
(
  // Clock and reset
  input  wire logic         CLK_IN,
  input  wire logic         RST_B_IN,
  // Misc feature-enable MSR access
  input  wire logic         MSR_WR_IN,
  input  wire logic [63:0]  MSR_WDATA_IN,
  output logic      [63:0]  MSR_RDATA_OUT,
  // String operation request
  input  wire logic         STR_REQ_IN,
  input  wire string_cmd_s  STR_CMD_IN,
  output logic              STR_BUSY_OUT,
  output logic              STR_DONE_OUT,
  output logic              STR_FAST_OUT,
  // Ordinary stores
  input  wire logic         ORD_REQ_IN,
  input  wire store_s       ORD_STORE_IN,
  output logic              ORD_READY_OUT,
  // Interrupt and return from handler
  input  wire logic         INT_REQ_IN,
  input  wire logic         RESUME_IN,
  output logic              INT_TAKEN_OUT,
  output string_ctx_s       CTX_OUT,
  // Store port towards memory
  input  wire logic         MEM_READY_IN,
  input  wire logic         MEM_VIS_IN,
  output logic              MEM_VALID_OUT,
  output store_s            MEM_STORE_OUT
);

  typedef enum logic [3:0] {
    S_IDLE, S_PRIOR, S_BATCH, S_ISSUE, S_STEP_WAIT,
    S_END_DRAIN, S_INT_DRAIN, S_HANDLER, S_RESUME_DRAIN
  } state_e;

  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_n;

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  state_e             state_q;
  logic [63:0]        misc_q;
  string_ctx_s        ctx_q;
  logic [DATA_W-1:0]  value_q;
  logic [1:0]         size_q;
  logic               move_q;
  logic               desc_q;
  logic               wb_q;
  logic               fast_q;
  logic [BATCH_W-1:0] batch_n_q;
  logic               mem_valid_q;
  store_s             mem_q;
  logic               ord_ready_q;
  logic               done_q;
  logic               int_taken_q;
  string_ctx_s        ctx_out_q;
  logic               busy_q;

  logic               all_clear;
  logic               mem_fire;
  logic               can_load;
  logic               ord_take;
  logic               str_load;
  logic               batch_start;
  logic               fast_now;
  logic [BATCH_W-1:0] per_line;
  logic [BATCH_W-1:0] batch_n;
  logic [BATCH_W-1:0] seq_off;
  logic               seq_last;
  logic               tracker_clear;

  assign mem_fire = mem_valid_q && MEM_READY_IN;
  assign can_load = !mem_valid_q || MEM_READY_IN;
  assign ord_take = ORD_REQ_IN && ord_ready_q;
  assign str_load = (state_q == S_ISSUE) && can_load;
  // A store still held in the output register counts as not yet visible
  assign all_clear = tracker_clear && !mem_valid_q;

  // Fast mode needs the MSR bit and a write-back target
  assign fast_now = misc_q[FAST_EN_BIT] && wb_q;
  assign per_line = LINE_ELEMS_BYTE >> size_q;
  // Fast mode walks a line at a time; otherwise a single iteration per step
  assign batch_n  = !fast_now ? BATCH_W'(1) :
                    (ctx_q.count < CNT_W'(per_line)) ? ctx_q.count[BATCH_W-1:0] : per_line;
  assign batch_start = (state_q == S_BATCH) && (ctx_q.count != '0) && !INT_REQ_IN;

  line_batch_sequencer u_seq (
    .clk        (CLK_IN),
    .rst_n      (rst_n),
    .start_in   (batch_start),
    .count_in   (batch_n),
    .reverse_in (fast_now),
    .advance_in (str_load),
    .offset_out (seq_off),
    .last_out   (seq_last)
  );

  visibility_tracker u_vis (
    .clk        (CLK_IN),
    .rst_n      (rst_n),
    .issue_in   (mem_fire),
    .visible_in (MEM_VIS_IN),
    .clear_out  (tracker_clear)
  );

  // Feature-enable MSR
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      misc_q <= MISC_ENABLE_RST;
    end else if (MSR_WR_IN) begin
      misc_q <= MSR_WDATA_IN;
    end
  end

  // Sequencing of string operations, interrupts and handler
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (STR_REQ_IN) begin
            state_q <= S_PRIOR;
          end
        end
        S_PRIOR: begin
          if (all_clear) begin
            state_q <= S_BATCH;
          end
        end
        S_BATCH: begin
          if (ctx_q.count == '0) begin
            state_q <= S_END_DRAIN;
          end else if (INT_REQ_IN) begin
            state_q <= S_INT_DRAIN;
          end else begin
            state_q <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          if (str_load && seq_last) begin
            state_q <= fast_q ? S_BATCH : S_STEP_WAIT;
          end
        end
        S_STEP_WAIT: begin
          if (all_clear) begin
            state_q <= S_BATCH;
          end
        end
        S_END_DRAIN: begin
          if (all_clear) begin
            state_q <= S_IDLE;
          end
        end
        S_INT_DRAIN: begin
          if (all_clear) begin
            state_q <= S_HANDLER;
          end
        end
        S_HANDLER: begin
          if (RESUME_IN) begin
            state_q <= S_RESUME_DRAIN;
          end
        end
        S_RESUME_DRAIN: begin
          // Handler stores go visible before iteration k+1 issues
          if (all_clear) begin
            state_q <= S_BATCH;
          end
        end
      endcase
    end
  end

  // Architectural string context, advanced only per completed batch
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ctx_q     <= '0;
      value_q   <= '0;
      size_q    <= '0;
      move_q    <= 1'b0;
      desc_q    <= 1'b0;
      wb_q      <= 1'b0;
      fast_q    <= 1'b0;
      batch_n_q <= BATCH_W'(1);
    end else if (state_q == S_IDLE && STR_REQ_IN) begin
      ctx_q.ip    <= STR_CMD_IN.ip;
      ctx_q.dst   <= STR_CMD_IN.dst;
      ctx_q.src   <= STR_CMD_IN.src;
      ctx_q.count <= STR_CMD_IN.count;
      value_q     <= STR_CMD_IN.value;
      size_q      <= STR_CMD_IN.size_log2;
      move_q      <= STR_CMD_IN.is_move;
      desc_q      <= STR_CMD_IN.descending;
      wb_q        <= STR_CMD_IN.wb_target;
    end else if (batch_start) begin
      // Mode is frozen per batch so an MSR write never splits a line walk
      fast_q    <= fast_now;
      batch_n_q <= batch_n;
    end else if (str_load && seq_last) begin
      ctx_q.dst   <= step_addr(ctx_q.dst, batch_n_q, size_q, desc_q);
      if (move_q) begin
        ctx_q.src <= step_addr(ctx_q.src, batch_n_q, size_q, desc_q);
      end
      ctx_q.count <= ctx_q.count - CNT_W'(batch_n_q);
    end
  end

  // Store output register, shared in program order by both sources
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      mem_valid_q <= 1'b0;
      mem_q       <= '0;
    end else if (ord_take) begin
      mem_valid_q <= 1'b1;
      mem_q       <= ORD_STORE_IN;
    end else if (str_load) begin
      mem_valid_q     <= 1'b1;
      mem_q.addr      <= step_addr(ctx_q.dst, seq_off, size_q, desc_q);
      mem_q.data      <= value_q;
      mem_q.size_log2 <= size_q;
    end else if (mem_fire) begin
      mem_valid_q <= 1'b0;
    end
  end

  // Ordinary stores only outside a string operation or inside the handler
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ord_ready_q <= 1'b0;
    end else begin
      ord_ready_q <= ((state_q == S_IDLE && !STR_REQ_IN) ||
                      (state_q == S_HANDLER && !RESUME_IN)) &&
                     !ord_take && !(mem_valid_q && !MEM_READY_IN);
    end
  end

  // Status and saved context
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      done_q      <= 1'b0;
      int_taken_q <= 1'b0;
      ctx_out_q   <= '0;
      busy_q      <= 1'b0;
    end else begin
      done_q      <= (state_q == S_END_DRAIN) && all_clear;
      int_taken_q <= (state_q == S_INT_DRAIN) && all_clear;
      busy_q      <= (state_q != S_IDLE) || STR_REQ_IN;
      if (state_q == S_INT_DRAIN && all_clear) begin
        ctx_out_q <= ctx_q;
      end
    end
  end

  assign MSR_RDATA_OUT = misc_q;
  assign STR_BUSY_OUT  = busy_q;
  assign STR_DONE_OUT  = done_q;
  assign STR_FAST_OUT  = fast_q;
  assign ORD_READY_OUT = ord_ready_q;
  assign INT_TAKEN_OUT = int_taken_q;
  assign CTX_OUT       = ctx_out_q;
  assign MEM_VALID_OUT = mem_valid_q;
  assign MEM_STORE_OUT = mem_q;

endmodule

// >>> core/string_order_pkg.sv
package string_order_pkg;

  localparam int ADDR_W  = 32;
  localparam int DATA_W  = 64;
  localparam int CNT_W   = 32;
  localparam int BATCH_W = 7;
  localparam int VIS_W   = 8;

  // Elements of one cache line bound how far fast mode may reorder
  localparam int LINE_BYTES = 64;

  localparam int                  FAST_EN_BIT     = 0;
  localparam logic [63:0]         MISC_ENABLE_RST = 64'h0000_0000_0000_0001;
  localparam logic [BATCH_W-1:0]  LINE_ELEMS_BYTE = BATCH_W'(LINE_BYTES);

  typedef struct packed {
    logic [ADDR_W-1:0] ip;
    logic [ADDR_W-1:0] dst;
    logic [ADDR_W-1:0] src;
    logic [CNT_W-1:0]  count;
    logic [DATA_W-1:0] value;
    logic [1:0]        size_log2;
    logic              is_move;
    logic              descending;
    logic              wb_target;
  } string_cmd_s;

  typedef struct packed {
    logic [ADDR_W-1:0] ip;
    logic [ADDR_W-1:0] dst;
    logic [ADDR_W-1:0] src;
    logic [CNT_W-1:0]  count;
  } string_ctx_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [1:0]        size_log2;
  } store_s;

  // Address after n elements of 2**size bytes in the given direction
  function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0]  base,
                                                  input logic [BATCH_W-1:0] n,
                                                  input logic [1:0]         size,
                                                  input logic               desc);
    logic [ADDR_W-1:0] bytes;
    bytes = ADDR_W'(n) << size;
    return desc ? base - bytes : base + bytes;
  endfunction

endpackage

// >>> core/line_batch_sequencer.sv
`timescale 1ns/1ns
module line_batch_sequencer
  import string_order_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               start_in,
  input  wire logic [BATCH_W-1:0] count_in,
  input  wire logic               reverse_in,
  input  wire logic               advance_in,
  output logic      [BATCH_W-1:0] offset_out,
  output logic                    last_out
);

  logic [BATCH_W-1:0] idx_q;
  logic [BATCH_W-1:0] n_q;
  logic               rev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= '0;
      n_q   <= BATCH_W'(1);
      rev_q <= 1'b0;
    end else if (start_in) begin
      idx_q <= '0;
      n_q   <= count_in;
      rev_q <= reverse_in;
    end else if (advance_in) begin
      idx_q <= idx_q + BATCH_W'(1);
    end
  end

  // Reversed walk inside a line is the permitted reordering
  assign offset_out = rev_q ? (n_q - BATCH_W'(1) - idx_q) : idx_q;
  assign last_out   = (idx_q == n_q - BATCH_W'(1));

endmodule

// >>> core/visibility_tracker.sv
`timescale 1ns/1ns
module visibility_tracker
  import string_order_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic issue_in,
  input  wire logic visible_in,
  output logic      clear_out
);

  logic [VIS_W-1:0] pend_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= '0;
    end else if (issue_in && !visible_in) begin
      pend_q <= pend_q + VIS_W'(1);
    end else if (!issue_in && visible_in && pend_q != '0) begin
      pend_q <= pend_q - VIS_W'(1);
    end
  end

  assign clear_out = (pend_q == '0);

endmodule

// >>> tb/mem_observer.sv
`timescale 1ns/1ns
module mem_observer (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Store port
  input  wire logic valid,
  output logic      ready,
  output logic      vis
);
  int pend = 0;
  bit acc;
  bit hit;

  initial begin
    ready = 0;
    vis = 0;
  end

  // Visibility may lag acceptance by any amount, never in the same cycle
  always @(posedge clk) begin
    acc = valid && ready;
    hit = vis;
    #1;
    pend = rst_n ? pend + acc - hit : 0;
    vis = rst_n && pend > 0 && $urandom_range(0, 3) == 0;
    ready = rst_n && $urandom_range(0, 3) != 0;
  end
endmodule

// >>> tb/string_store_ordering_asserts.sv
`timescale 1ns/1ns
module order_checker
  import string_order_pkg::*;
(
  input wire logic        CLK_IN,
  input wire logic        RST_B_IN,
  input wire logic        MSR_WR_IN,
  input wire logic [63:0] MSR_WDATA_IN,
  input wire logic [63:0] MSR_RDATA_OUT,
  input wire logic        STR_REQ_IN,
  input wire string_cmd_s STR_CMD_IN,
  input wire logic        STR_BUSY_OUT,
  input wire logic        STR_DONE_OUT,
  input wire logic        STR_FAST_OUT,
  input wire logic        ORD_REQ_IN,
  input wire store_s      ORD_STORE_IN,
  input wire logic        ORD_READY_OUT,
  input wire logic        INT_REQ_IN,
  input wire logic        RESUME_IN,
  input wire logic        INT_TAKEN_OUT,
  input wire string_ctx_s CTX_OUT,
  input wire logic        MEM_READY_IN,
  input wire logic        MEM_VIS_IN,
  input wire logic        MEM_VALID_OUT,
  input wire store_s      MEM_STORE_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  logic [7:0]        outst_q;
  logic              hnd_q;
  logic              wb_q;
  logic [ADDR_W-1:0] ip_q;

  // Stores accepted by memory but not yet globally visible
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN)
      outst_q <= 8'h00;
    else
      outst_q <= outst_q + 8'(MEM_VALID_OUT & MEM_READY_IN) - 8'(MEM_VIS_IN);
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      hnd_q <= 1'b0;
      wb_q <= 1'b0;
      ip_q <= '0;
    end else begin
      hnd_q <= INT_TAKEN_OUT | (hnd_q & ~RESUME_IN);
      if (STR_REQ_IN && !STR_BUSY_OUT) begin
        wb_q <= STR_CMD_IN.wb_target;
        ip_q <= STR_CMD_IN.ip;
      end
    end
  end

  AST_MSR_WR: assert property (
    MSR_WR_IN |=> MSR_RDATA_OUT == $past(MSR_WDATA_IN))
    else $error("feature register write lost");
  AST_SLOW_SERIAL: assert property (
    STR_BUSY_OUT && $past(STR_BUSY_OUT) && !STR_FAST_OUT && !hnd_q && $rose(MEM_VALID_OUT)
    |-> outst_q == 8'h00)
    else $error("slow string store issued before previous visible");
  AST_FAST_WB: assert property (
    STR_BUSY_OUT && STR_FAST_OUT && MEM_VALID_OUT && !hnd_q |-> wb_q)
    else $error("fast mode on a non write-back target");
  AST_DONE_CLEAR: assert property (
    STR_DONE_OUT |-> outst_q == 8'h00 && !MEM_VALID_OUT)
    else $error("done while stores still pending");
  AST_DONE_PULSE: assert property (
    STR_DONE_OUT |=> !STR_DONE_OUT [*2])
    else $error("done longer than one cycle");
  AST_ORD_ANSWER: assert property (
    ORD_REQ_IN && ORD_READY_OUT |=> MEM_VALID_OUT && MEM_STORE_OUT == $past(ORD_STORE_IN))
    else $error("ordinary store not offered next cycle");
  AST_ORD_BLOCKED: assert property (
    STR_BUSY_OUT && $past(STR_BUSY_OUT) && !hnd_q && !$past(hnd_q) && !INT_TAKEN_OUT
    |-> !ORD_READY_OUT)
    else $error("ordinary store accepted inside string operation");
  AST_MEM_HOLD: assert property (
    MEM_VALID_OUT && !MEM_READY_IN |=> MEM_VALID_OUT && $stable(MEM_STORE_OUT))
    else $error("offered store dropped or changed");
  AST_INT_DRAIN: assert property (
    INT_TAKEN_OUT |-> outst_q == 8'h00 && !MEM_VALID_OUT)
    else $error("handler entered before string stores visible");
  AST_INT_IP: assert property (
    INT_TAKEN_OUT |-> CTX_OUT.ip == ip_q && $past(INT_REQ_IN))
    else $error("saved pointer is not the string instruction");
  AST_CTX_HOLD: assert property (
    INT_TAKEN_OUT |=> $stable(CTX_OUT) [*4])
    else $error("saved context not held");

  cover property (STR_DONE_OUT && STR_FAST_OUT);
  cover property (INT_TAKEN_OUT);
  cover property (ORD_REQ_IN && ORD_READY_OUT && hnd_q);
endmodule

bind string_store_ordering order_checker chk (.*);

// >>> tb/testbench.sv
`timescale 1ns/1ns
module testbench
  import string_order_pkg::*;
;
  logic              clk = 0;
  logic              rst_n = 0;
  logic              msr_wr = 0;
  logic [63:0]       msr_wd = '0;
  logic              str_req = 0;
  string_cmd_s       cmd = '0;
  logic              ord_req = 0;
  store_s            ord_st = '0;
  logic              int_req = 0;
  logic              resume = 0;
  logic              mem_rdy;
  logic              mem_vis;
  logic [63:0]       msr_rd;
  logic              busy;
  logic              done;
  logic              fast;
  logic              ord_rdy;
  logic              taken;
  logic              mem_vld;
  string_ctx_s       ctx;
  store_s            mem_st;
  logic [ADDR_W-1:0] log_q[$];
  int                err_total = 0;
  int                samples_checked = 0;

  always #50 clk = ~clk;

  string_store_ordering dut (
    .CLK_IN(clk), .RST_B_IN(rst_n), .MSR_WR_IN(msr_wr), .MSR_WDATA_IN(msr_wd),
    .MSR_RDATA_OUT(msr_rd), .STR_REQ_IN(str_req), .STR_CMD_IN(cmd), .STR_BUSY_OUT(busy),
    .STR_DONE_OUT(done), .STR_FAST_OUT(fast), .ORD_REQ_IN(ord_req), .ORD_STORE_IN(ord_st),
    .ORD_READY_OUT(ord_rdy), .INT_REQ_IN(int_req), .RESUME_IN(resume),
    .INT_TAKEN_OUT(taken), .CTX_OUT(ctx), .MEM_READY_IN(mem_rdy), .MEM_VIS_IN(mem_vis),
    .MEM_VALID_OUT(mem_vld), .MEM_STORE_OUT(mem_st));

  mem_observer obs (.clk(clk), .rst_n(rst_n), .valid(mem_vld), .ready(mem_rdy),
    .vis(mem_vis));

  always @(posedge clk) begin
    if (mem_vld && mem_rdy)
      log_q.push_back(mem_st.addr);
  end

  task automatic chk(string nm, logic [63:0] got, logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic step(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_hi(ref logic s);
    for (int i = 0; i < 3000 && s !== 1'b1; i++)
      step();
    chk("handshake", s, 1'b1);
  endtask

  task automatic ost(logic [ADDR_W-1:0] a);
    wait_hi(ord_rdy);
    ord_st = '{addr: a, data: {$urandom, $urandom}, size_log2: 2'h2};
    ord_req = 1;
    step();
    ord_req = 0;
    step();
  endtask

  // Issue order: reversed inside each line-sized batch when fast
  function automatic logic [ADDR_W-1:0] exp_addr(int n, int c, int sz, bit f, bit ds,
                                                 logic [ADDR_W-1:0] d);
    int l;
    int b;
    int m;
    int j;
    l = f ? (LINE_BYTES >> sz) : 1;
    b = n / l * l;
    m = (c - b < l) ? c - b : l;
    j = b + m - 1 - (n - b);
    return ds ? d - ADDR_W'(j << sz) : d + ADDR_W'(j << sz);
  endfunction

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    step(30000);
    err_total++;
    end_of_test();
  end

  initial begin
    int c;
    int sz;
    int n0;
    int k;
    bit fen;
    logic [63:0] v;
    void'($urandom(32'he379));
    step(4);
    rst_n = 1;
    step(3);
    chk("msr_reset", msr_rd, MISC_ENABLE_RST);
    for (int i = 0; i < 14; i++) begin
      fen = i % 2;
      v = {$urandom, $urandom};
      v[FAST_EN_BIT] = fen;
      msr_wd = v;
      msr_wr = 1;
      step();
      msr_wr = 0;
      step();
      chk("msr", msr_rd, v);
      sz = $urandom_range(0, 3);
      c = (i < 2) ? 1 : (i < 6) ? (LINE_BYTES >> sz) + 1 : $urandom_range(2, 20);
      cmd = '{ip: $urandom, dst: $urandom, src: $urandom, count: c, value: {$urandom, $urandom},
              size_log2: sz, is_move: $urandom, descending: $urandom, wb_target: i % 4 != 3};
      n0 = log_q.size();
      ost(32'hFFFF_0000 + i);
      str_req = 1;
      step();
      str_req = 0;
      wait_hi(done);
      chk("first", log_q[n0], 32'hFFFF_0000 + i);
      chk("fast", fast, fen && cmd.wb_target);
      chk("count", log_q.size() - n0 - 1, c);
      for (int n = 0; n < c; n++)
        chk("addr", log_q[n0 + 1 + n], exp_addr(n, c, sz, fen && cmd.wb_target,
            cmd.descending, cmd.dst));
    end
    // Slow mode so that batch boundaries fall on every element and an interrupt lands mid-string
    msr_wd = 64'h0000_0000_0000_0000;
    msr_wr = 1;
    step();
    msr_wr = 0;
    step();
    chk("msr_off", msr_rd, 64'h0000_0000_0000_0000);
    cmd = '{ip: 32'h0000_0100, dst: 32'h0000_4000, src: 32'h0000_8000, count: 12,
            value: '0, size_log2: 2'h2, is_move: 1, descending: 0, wb_target: 1};
    n0 = log_q.size();
    str_req = 1;
    step();
    str_req = 0;
    step(12);
    int_req = 1;
    wait_hi(taken);
    int_req = 0;
    k = log_q.size() - n0;
    chk("ctx_ip", ctx.ip, 32'h0000_0100);
    chk("ctx_dst", ctx.dst, 32'h0000_4000 + 4 * k);
    chk("ctx_src", ctx.src, 32'h0000_8000 + 4 * k);
    chk("ctx_count", ctx.count, 12 - k);
    ost(32'h0000_9000);
    resume = 1;
    step();
    resume = 0;
    wait_hi(done);
    chk("handler", log_q[n0 + k], 32'h0000_9000);
    chk("total", log_q.size() - n0, 13);
    chk("slow", fast, 1'b0);
    for (int j = k; j < 12; j++)
      chk("resumed", log_q[n0 + j + 1], 32'h0000_4000 + 4 * j);
    step(5);
    end_of_test();
  end
endmodule
